// ==== src/pdsh_params.svh ====
`ifndef PDSH_PARAMS_SVH
`define PDSH_PARAMS_SVH
// What this block does
// - pwm pin is sampled; duty measured and turned into an 11-bit level code
// - full 11 bits only when a sample period is shorter than narrowest pulse
// - two-bit sample-rate selection: 800 kHz, 4 MHz or 24 MHz, the last capped at the 20 MHz clock
// - resolution follows the ratio of sample rate to pwm frequency
// - lowest adequate sample rate is recommended to save quiescent current
// - three-bit hysteresis selection, codes 000 to 110 give thresholds of 1 to 64 lsbs
// - setting n needs a 2^n count move before the output follows
// - hysteresis applies only on a reversal; output frozen until the threshold is reached
// - after the threshold is passed, same-direction changes follow at once
// - pwm enabled and no pulse for the timeout period sets the code to 0, or to full scale if the pin stays high
// - pwm-only mode ignores the bus code and forwards the measured code

// =====================================================================
// widths
`define PDSH_CODE_W 11
`define PDSH_CODE_MAX 11'h7FF
`define PDSH_FULL_SCALE 16'h07FF
`define PDSH_CNT_W 16
`define PDSH_NUM_W 27
`define PDSH_IDX_W 5
`define PDSH_SDIV_W 5
`define PDSH_TMO_W 20
`define PDSH_HYST_MAX 3'h6

// =====================================================================
// clock and sample rates
`define PDSH_CLK_HZ 20000000
`define PDSH_CLK_PERIOD_NS 50
`define PDSH_RATE_SLOW_HZ 800000
`define PDSH_RATE_MID_HZ 4000000
`define PDSH_RATE_FAST_HZ 24000000
`define PDSH_DIV_CALC(hz) (((`PDSH_CLK_HZ / (hz)) < 1) ? 1 : (`PDSH_CLK_HZ / (hz)))

// =====================================================================
// no-pulse timeouts per sample rate
`define PDSH_TMO_SLOW_NS 25000000
`define PDSH_TMO_MID_NS 3000000
`define PDSH_TMO_FAST_NS 600000
`define PDSH_TMO_CYC(ns) ((ns) / `PDSH_CLK_PERIOD_NS)

`endif

// ==== src/pdsh_pkg.sv ====
`include "pdsh_params.svh"

package pdsh_pkg;

    // =====================================================================
    // selections
    typedef enum logic [1:0] {
        PDSH_RATE_SLOW = 2'b00,
        PDSH_RATE_MID = 2'b01,
        PDSH_RATE_FAST = 2'b10,
        PDSH_RATE_FAST_ALT = 2'b11
    } pdsh_rate_t;

    typedef enum logic [1:0] {
        PDSH_MODE_BUS = 2'b00,
        PDSH_MODE_PWM = 2'b01,
        PDSH_MODE_MUL_RAMP = 2'b10,
        PDSH_MODE_RAMP_MUL = 2'b11
    } pdsh_mode_t;

    typedef enum logic {
        PDSH_DIV_IDLE = 1'b0,
        PDSH_DIV_RUN = 1'b1
    } pdsh_div_state_t;

    // =====================================================================
    // state records
    typedef struct packed {
        pdsh_div_state_t st;
        logic [`PDSH_IDX_W-1:0] idx;
        logic [`PDSH_NUM_W-1:0] num;
        logic [`PDSH_CNT_W-1:0] den;
        logic [`PDSH_CNT_W-1:0] rem;
        logic [`PDSH_NUM_W-1:0] quo;
        logic [`PDSH_CODE_W-1:0] quot;
        logic done;
    } pdsh_div_t;

    typedef struct packed {
        logic [`PDSH_SDIV_W-1:0] sdiv_cnt;
        logic smp_prev;
        logic [`PDSH_CNT_W-1:0] high_cnt;
        logic [`PDSH_CNT_W-1:0] tot_cnt;
        logic have_period;
        logic [`PDSH_TMO_W-1:0] idle_cnt;
        logic timed_out;
        logic div_start;
        logic [`PDSH_CNT_W-1:0] div_high;
        logic [`PDSH_CNT_W-1:0] div_tot;
        logic [`PDSH_CODE_W-1:0] duty_code;
        logic [`PDSH_CODE_W-1:0] hyst_code;
        logic dir_up;
        logic [`PDSH_CODE_W-1:0] led_code;
        logic code_update;
    } pdsh_state_t;

endpackage

// ==== src/pdsh_divider.sv ====
`timescale 1ns/1ps
`include "pdsh_params.svh"

module pdsh_divider (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [`PDSH_CNT_W-1:0] high_cnt,
    input wire logic [`PDSH_CNT_W-1:0] tot_cnt,
    output logic busy,
    output logic done,
    output logic [`PDSH_CODE_W-1:0] quot
);
    import pdsh_pkg::*;

    pdsh_div_t s_r;
    pdsh_div_t s_nxt;
    logic [`PDSH_CNT_W:0] trial;
    logic [`PDSH_NUM_W-1:0] scaled;

    // =====================================================================
    // restoring division of high*2047 by total, one quotient bit per cycle
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        trial = {s_r.rem, s_r.num[`PDSH_NUM_W-1]};
        // high*2047 as high*2048 - high, avoids a multiplier
        scaled = {high_cnt, 11'h000} - {11'h000, high_cnt};
        case (s_r.st)
            PDSH_DIV_IDLE: begin
                if (start) begin
                    s_nxt.st = PDSH_DIV_RUN;
                    s_nxt.num = scaled;
                    s_nxt.den = tot_cnt;
                    s_nxt.rem = '0;
                    s_nxt.quo = '0;
                    s_nxt.idx = 5'(`PDSH_NUM_W - 1);
                end
            end
            PDSH_DIV_RUN: begin
                s_nxt.num = {s_r.num[`PDSH_NUM_W-2:0], 1'b0};
                if (trial >= {1'b0, s_r.den}) begin
                    s_nxt.rem = `PDSH_CNT_W'(trial - {1'b0, s_r.den});
                    s_nxt.quo = {s_r.quo[`PDSH_NUM_W-2:0], 1'b1};
                end else begin
                    s_nxt.rem = trial[`PDSH_CNT_W-1:0];
                    s_nxt.quo = {s_r.quo[`PDSH_NUM_W-2:0], 1'b0};
                end
                s_nxt.idx = s_r.idx - 5'h01;
                if (s_r.idx == '0) begin
                    s_nxt.st = PDSH_DIV_IDLE;
                    s_nxt.done = 1'b1;
                    // clamp guards against a miscounted period
                    s_nxt.quot = (|s_nxt.quo[`PDSH_NUM_W-1:`PDSH_CODE_W]) ?
                        `PDSH_CODE_MAX : s_nxt.quo[`PDSH_CODE_W-1:0];
                end
            end
            default: begin
                s_nxt.st = PDSH_DIV_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.st == PDSH_DIV_RUN);
    assign done = s_r.done;
    assign quot = s_r.quot;

endmodule

// ==== src/pdsh_sampler.sv ====
`timescale 1ns/1ps
`include "pdsh_params.svh"

module pdsh_sampler #(
    parameter int TMO_SLOW_CYC = `PDSH_TMO_CYC(`PDSH_TMO_SLOW_NS),
    parameter int TMO_MID_CYC = `PDSH_TMO_CYC(`PDSH_TMO_MID_NS),
    parameter int TMO_FAST_CYC = `PDSH_TMO_CYC(`PDSH_TMO_FAST_NS)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pwm_in,
    input wire logic pwm_enable,
    input wire pdsh_pkg::pdsh_rate_t sample_rate,
    input wire logic [2:0] hyst_sel,
    input wire pdsh_pkg::pdsh_mode_t bright_mode,
    input wire logic [`PDSH_CODE_W-1:0] bus_level_code,
    output logic [`PDSH_CODE_W-1:0] led_level_code,
    output logic [`PDSH_CODE_W-1:0] duty_code,
    output logic code_update,
    output logic pwm_timeout
);
    import pdsh_pkg::*;

    pdsh_state_t s_r;
    pdsh_state_t s_nxt;
    logic div_busy;
    logic div_done;
    logic [`PDSH_CODE_W-1:0] div_quot;
    logic pwm_on;
    logic tick;
    logic rise;
    logic [`PDSH_TMO_W-1:0] tmo_lim;
    logic [`PDSH_CODE_W:0] thr;
    logic [2:0] hyst_n;

    // =====================================================================
    // decoding of the sample-rate selection

    // core cycles per sample tick; 24 MHz cannot exceed the 20 MHz clock
    function automatic logic [`PDSH_SDIV_W-1:0] rate_div(input pdsh_rate_t r);
        case (r)
            PDSH_RATE_SLOW: rate_div = `PDSH_SDIV_W'(`PDSH_DIV_CALC(`PDSH_RATE_SLOW_HZ));
            PDSH_RATE_MID: rate_div = `PDSH_SDIV_W'(`PDSH_DIV_CALC(`PDSH_RATE_MID_HZ));
            default: rate_div = `PDSH_SDIV_W'(`PDSH_DIV_CALC(`PDSH_RATE_FAST_HZ));
        endcase
    endfunction

    // no-pulse timeout in core cycles for the selected rate
    function automatic logic [`PDSH_TMO_W-1:0] rate_tmo(input pdsh_rate_t r);
        case (r)
            PDSH_RATE_SLOW: rate_tmo = `PDSH_TMO_W'(TMO_SLOW_CYC);
            PDSH_RATE_MID: rate_tmo = `PDSH_TMO_W'(TMO_MID_CYC);
            default: rate_tmo = `PDSH_TMO_W'(TMO_FAST_CYC);
        endcase
    endfunction

    // =====================================================================
    // duty divider
    pdsh_divider u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(s_r.div_start),
        .high_cnt(s_r.div_high),
        .tot_cnt(s_r.div_tot),
        .busy(div_busy),
        .done(div_done),
        .quot(div_quot)
    );

    // =====================================================================
    // sampling, period measurement, timeout, hysteresis, mode select
    always_comb begin
        s_nxt = s_r;
        s_nxt.div_start = 1'b0;
        s_nxt.code_update = 1'b0;
        // measurement runs only while pwm is enabled and not in bus-only mode
        pwm_on = pwm_enable && (bright_mode != PDSH_MODE_BUS);
        tick = (s_r.sdiv_cnt == '0);
        rise = tick && !s_r.smp_prev && pwm_in;
        tmo_lim = rate_tmo(sample_rate);
        hyst_n = (hyst_sel > `PDSH_HYST_MAX) ? `PDSH_HYST_MAX : hyst_sel;
        thr = (`PDSH_CODE_W+1)'(1) << hyst_n;

        // sample tick generator; a slow rate leaves the counters idle longer
        if (tick) begin
            s_nxt.sdiv_cnt = rate_div(sample_rate) - 5'h01;
        end else begin
            s_nxt.sdiv_cnt = s_r.sdiv_cnt - 5'h01;
        end

        if (!pwm_on) begin
            s_nxt.smp_prev = 1'b0;
            s_nxt.high_cnt = '0;
            s_nxt.tot_cnt = '0;
            s_nxt.have_period = 1'b0;
            s_nxt.idle_cnt = '0;
            s_nxt.timed_out = 1'b0;
        end else begin
            // core cycles since the last rising edge, saturating
            if (rise) begin
                s_nxt.idle_cnt = '0;
                s_nxt.timed_out = 1'b0;
            end else if (s_r.idle_cnt >= tmo_lim) begin
                s_nxt.timed_out = 1'b1;
                s_nxt.have_period = 1'b0;
            end else begin
                s_nxt.idle_cnt = s_r.idle_cnt + 20'h00001;
            end
            if (tick) begin
                s_nxt.smp_prev = pwm_in;
                if (rise) begin
                    // a rising edge closes one period; a period that finds the
                    // divider busy is dropped rather than queued
                    if (s_r.have_period && !div_busy) begin
                        s_nxt.div_start = 1'b1;
                        s_nxt.div_high = s_r.high_cnt;
                        s_nxt.div_tot = s_r.tot_cnt;
                    end
                    s_nxt.high_cnt = 16'h0001;
                    s_nxt.tot_cnt = 16'h0001;
                    s_nxt.have_period = 1'b1;
                end else begin
                    // counts saturate; resolution is bounded by samples per period
                    if (s_r.tot_cnt != '1) begin
                        s_nxt.tot_cnt = s_r.tot_cnt + 16'h0001;
                    end
                    if (pwm_in && s_r.high_cnt != '1) begin
                        s_nxt.high_cnt = s_r.high_cnt + 16'h0001;
                    end
                end
            end
        end

        // a level held past the timeout reads as 0 % or 100 %, in step with the flag
        if (s_nxt.timed_out && pwm_on) begin
            s_nxt.duty_code = s_nxt.smp_prev ? `PDSH_CODE_MAX : '0;
            s_nxt.hyst_code = s_nxt.duty_code;
        end else if (div_done) begin
            s_nxt.duty_code = div_quot;
            if (div_quot > s_r.hyst_code) begin
                // same direction passes at once, a reversal must clear 2^n
                if (s_r.dir_up ||
                    ({1'b0, div_quot - s_r.hyst_code} >= thr)) begin
                    s_nxt.hyst_code = div_quot;
                    s_nxt.dir_up = 1'b1;
                end
            end else if (div_quot < s_r.hyst_code) begin
                if (!s_r.dir_up ||
                    ({1'b0, s_r.hyst_code - div_quot} >= thr)) begin
                    s_nxt.hyst_code = div_quot;
                    s_nxt.dir_up = 1'b0;
                end
            end
        end
        if (!pwm_on) begin
            s_nxt.duty_code = '0;
        end

        // pwm-only mode forwards the filtered duty code, others the bus code
        if (bright_mode == PDSH_MODE_PWM) begin
            s_nxt.led_code = pwm_enable ? s_nxt.hyst_code : '0;
        end else begin
            s_nxt.led_code = bus_level_code;
        end
        s_nxt.code_update = (s_nxt.led_code != s_r.led_code);
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{dir_up: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state record
    assign led_level_code = s_r.led_code;
    assign duty_code = s_r.duty_code;
    assign code_update = s_r.code_update;
    assign pwm_timeout = s_r.timed_out && !s_r.smp_prev;

endmodule

// ==== verif/pdsh_sampler_properties.sv ====
`timescale 1ns/1ps

module pdsh_sampler_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pwm_in,
    input wire logic pwm_enable,
    input wire pdsh_pkg::pdsh_rate_t sample_rate,
    input wire logic [2:0] hyst_sel,
    input wire pdsh_pkg::pdsh_mode_t bright_mode,
    input wire logic [10:0] bus_level_code,
    input wire logic [10:0] led_level_code,
    input wire logic [10:0] duty_code,
    input wire logic code_update,
    input wire logic pwm_timeout
);
    import pdsh_pkg::*;
    // =====
    // helpers
    logic [11:0] gap;
    // distance the forwarded code lags the measured one
    assign gap = (duty_code > led_level_code) ? {1'b0, duty_code - led_level_code}
                                              : {1'b0, led_level_code - duty_code};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // pwm mode with measuring on across two edges
    sequence pwm_steady;
        bright_mode == PDSH_MODE_PWM && pwm_enable ##1 bright_mode == PDSH_MODE_PWM && pwm_enable;
    endsequence
    // =====
    // properties
    chk_move_pulses: assert property ($changed(led_level_code) |-> code_update)
        else $error("level code moved without update pulse");
    chk_pulse_moves: assert property (
        code_update |-> led_level_code != $past(led_level_code))
        else $error("update pulse without a new level code");
    chk_bus_follow: assert property ($past(rst_n) && bright_mode != PDSH_MODE_PWM &&
        $past(bright_mode) != PDSH_MODE_PWM |-> led_level_code == $past(bus_level_code))
        else $error("bus mode does not forward bus code");
    chk_duty_off: assert property (
        !pwm_enable && $past(!pwm_enable) |-> duty_code == 0)
        else $error("duty code not zero while measuring is off");
    chk_led_off: assert property (bright_mode == PDSH_MODE_PWM && !pwm_enable ##1
        bright_mode == PDSH_MODE_PWM && !pwm_enable |-> led_level_code == 0)
        else $error("pwm mode level not zero while measuring is off");
    chk_timeout_zero: assert property (pwm_timeout |-> duty_code == 0)
        else $error("timeout with nonzero duty code");
    chk_pwm_result: assert property (
        pwm_steady ##0 code_update && $changed(duty_code) |-> led_level_code == duty_code)
        else $error("pwm mode level differs from new duty code");
    chk_hyst_none: assert property (pwm_steady ##0 hyst_sel == 3'h0 &&
        $stable(hyst_sel) && $changed(duty_code) |-> led_level_code == duty_code)
        else $error("zero hysteresis held the level code");
    chk_hyst_gap: assert property (pwm_steady ##0 hyst_sel <= 3'h6 &&
        $stable(hyst_sel) && $changed(duty_code) && led_level_code != duty_code |->
        gap < (12'h001 << hyst_sel))
        else $error("level code frozen beyond hysteresis threshold");
endmodule

// ==== verif/pdsh_pwm_src.sv ====
`timescale 1ns/1ps

module pdsh_pwm_src (
    input wire logic core_clk,
    input wire logic run,
    input wire logic [15:0] per,
    input wire logic [15:0] hi,
    output logic pwm
);
    // =====
    // pwm source
    logic [15:0] cnt = 16'h0000;
    logic [15:0] per_r = 16'h0001;
    logic [15:0] hi_r = 16'h0000;
    // new shape taken only at a period edge so no period is ever mixed
    always @(negedge core_clk) begin
        cnt <= (cnt + 16'h0001 >= per_r) ? 16'h0000 : cnt + 16'h0001;
        if (cnt + 16'h0001 >= per_r) begin
            per_r <= per;
            hi_r <= hi;
        end
    end
    // a stopped source drives the pin low
    assign pwm = run && (cnt < hi_r);
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps

module tb;
    import pdsh_pkg::*;
    // =====
    // bench signals
    localparam int TS = 1600;
    localparam int TM = 1400;
    localparam int TF = 1200; // must exceed the 1023-cycle hysteresis period
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwm_in;
    logic pwm_enable = 1'b1;
    pdsh_rate_t sample_rate = PDSH_RATE_FAST;
    logic [2:0] hyst_sel = 3'h0;
    pdsh_mode_t bright_mode = PDSH_MODE_PWM;
    logic [10:0] bus_level_code = 11'h000;
    logic [10:0] led_level_code;
    logic [10:0] duty_code;
    logic code_update;
    logic pwm_timeout;
    logic src_run = 1'b0;
    logic [15:0] src_per = 16'h01F4;
    logic [15:0] src_hi = 16'h007D;
    logic pwm_d = 1'b0;
    int since_rise = 0;
    int error_cnt = 0;
    int compares = 0;
    int m_code;
    logic m_up;
    // small timeouts keep the run short
    pdsh_sampler #(.TMO_SLOW_CYC(TS), .TMO_MID_CYC(TM), .TMO_FAST_CYC(TF)) dut_u (
        .core_clk, .rst_n, .pwm_in, .pwm_enable, .sample_rate, .hyst_sel, .bright_mode,
        .bus_level_code, .led_level_code, .duty_code, .code_update, .pwm_timeout);
    pdsh_pwm_src src_u (.core_clk, .run(src_run), .per(src_per), .hi(src_hi), .pwm(pwm_in));
    // clock, and cycles since the last rising pin level
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        pwm_d <= pwm_in;
        since_rise <= (pwm_in && !pwm_d) ? 0 : since_rise + 1;
    end
    // =====
    // checks and shared steps
    task automatic cmp_code(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t code %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got);
        compares++;
        if (got !== 1'b1) begin
            error_cnt++;
            $display("FAIL %0t condition not met", $time);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // wait covers the shape switch plus one whole period and the divide
    task automatic shape(input int per, input int hi);
        src_per = 16'(per);
        src_hi = 16'(hi);
        src_run = 1'b1;
        repeat (2 * per + 80) @(negedge core_clk);
    endtask
    // one duty step; period 1023 makes the duty code twice the high count
    task automatic hstep(input int hi, input int thr);
        int d;
        d = hi * 2;
        shape(1023, hi);
        if (d > m_code && (m_up || d - m_code >= thr)) begin
            m_code = d;
            m_up = 1'b1;
        end else if (d < m_code && (!m_up || m_code - d >= thr)) begin
            m_code = d;
            m_up = 1'b0;
        end
        cmp_code(duty_code, 11'(d));
        cmp_code(led_level_code, 11'(m_code));
    endtask
    // =====
    // scenarios
    task automatic t_rates();
        int lim [4] = '{TS, TM, TF, TF};
        for (int r = 0; r < 4; r++) begin
            sample_rate = pdsh_rate_t'(r);
            shape(500, 125);
            repeat (600) @(negedge core_clk);
            cmp_code(duty_code, 11'd511);
            cmp_code(led_level_code, 11'd511);
            src_run = 1'b0;
            for (int i = 0; i < 3000 && pwm_timeout !== 1'b1; i++) @(negedge core_clk);
            cmp_flag(since_rise >= lim[r] - 2 && since_rise <= lim[r] + 40);
            cmp_code(led_level_code, 11'h000);
        end
    endtask
    task automatic t_hyst();
        int thr;
        sample_rate = PDSH_RATE_FAST;
        hyst_sel = 3'h0;
        shape(1023, 50);
        shape(1023, 300);
        m_code = 600;
        m_up = 1'b1;
        for (int n = 0; n < 8; n++) begin
            hyst_sel = 3'(n); // every setting software may pick
            thr = 1 << ((n > 6) ? 6 : n);
            hstep(300, thr);
            hstep(299, thr);
            hstep(300 - thr, thr);
            hstep(299 - thr, thr);
        end
    endtask
    task automatic t_modes();
        int m;
        // pwm-only first while the measured code stands; bus-only stops measuring, so last
        for (int k = 0; k < 4; k++) begin
            m = (k + 1) % 4;
            bright_mode = pdsh_mode_t'(m);
            bus_level_code = 11'h5A5 ^ 11'(m);
            repeat (3) @(negedge core_clk);
            cmp_code(led_level_code, (m == 1) ? 11'(m_code) : bus_level_code);
            cmp_code(duty_code, (m == 0) ? 11'h000 : 11'd470);
        end
    endtask
    task automatic t_off();
        bright_mode = PDSH_MODE_PWM;
        pwm_enable = 1'b0;
        repeat (3) @(negedge core_clk);
        cmp_code(duty_code, 11'h000);
        cmp_code(led_level_code, 11'h000);
    endtask
    // main sequence, and a watchdog in case a wait hangs
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_rates();
        t_hyst();
        t_modes();
        t_off();
        give_verdict();
    end
    initial begin
        #(95000 * 50);
        error_cnt++;
        give_verdict();
    end
endmodule

bind pdsh_sampler pdsh_sampler_properties chk_u (.core_clk, .rst_n, .pwm_in, .pwm_enable,
    .sample_rate, .hyst_sel, .bright_mode, .bus_level_code, .led_level_code, .duty_code,
    .code_update, .pwm_timeout);
